/* File: design/fsp_top.sv */
// flash sector program/erase access and protection with apb registers
module fsp_top (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // mode straps and tool presence, asynchronous pins
    input  wire logic [1:0]  mode_sel_in,
    input  wire logic        tool_attached_in,
    // application drive for link pins, bit 0 clock, bit 1 data
    input  wire logic [1:0]  app_pin_o_in,
    input  wire logic [1:0]  app_pin_oe_in,
    // pad drive for link pins
    output logic      [1:0]  link_pin_o_out,
    output logic      [1:0]  link_pin_oe_out,
    // status
    output logic             readout_protect_option_out,
    output logic             busy_out
);
    logic [1:0]             rst_sync_q;
    logic                   rst_b;
    logic [1:0]             mode_s1_q;
    logic [1:0]             mode_s2_q;
    logic                   tool_s1_q;
    logic                   tool_s2_q;
    fsp_pkg::fsp_mode_e     mode;
    logic                   pready_q;
    logic                   pslverr_q;
    logic [31:0]            prdata_q;
    logic                   acc;
    logic                   wr_acc;
    logic                   mapped;
    logic [7:0]             ctrl_q;
    logic [15:0]            addr_q;
    logic [7:0]             wdat_q;
    logic                   prot_q;
    logic                   busy_q;
    logic [1:0]             pin_o_q;
    logic [1:0]             pin_oe_q;
    fsp_pkg::fsp_state_e    state_q;
    logic [fsp_pkg::AW-1:0] cnt_q;
    logic [fsp_pkg::AW-1:0] end_q;
    logic                   opt_clr_q;
    logic [16:0]            diff;
    logic [fsp_pkg::AW-1:0] idx_a;
    fsp_pkg::fsp_sect_e     sect_a;
    logic                   full_mode;
    logic                   alter_ok;
    logic                   pending;
    logic                   grant_be;
    logic                   grant_se;
    logic                   grant_pg;
    logic                   grant_ow;
    logic                   refuse;
    logic                   finish;
    logic [7:0]             stat;

    fsp_arr_if arr ();

    fsp_flash_array u_array (
        .clk_in (clk_in),
        .arr    (arr.mem)
    );

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // pin synchronisers; straps are static so a bus of two is safe
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
            tool_s1_q <= 1'b0;
            tool_s2_q <= 1'b0;
        end else begin
            mode_s1_q <= mode_sel_in;
            mode_s2_q <= mode_s1_q;
            tool_s1_q <= tool_attached_in;
            tool_s2_q <= tool_s1_q;
        end
    end
    assign mode = fsp_pkg::fsp_mode_e'(mode_s2_q);

    // link pins belong to the tool whenever it is plugged in
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pin_o_q  <= 2'h0;
            pin_oe_q <= 2'h0;
        end else begin
            pin_o_q  <= tool_s2_q ? 2'h0 : app_pin_o_in;
            pin_oe_q <= tool_s2_q ? 2'h0 : app_pin_oe_in;
        end
    end

    // target address to array index and sector
    assign diff  = {1'b0, addr_q} - fsp_pkg::FLASH_BASE;
    assign idx_a = diff[fsp_pkg::AW-1:0];
    always_comb begin
        if ({1'b0, addr_q} < fsp_pkg::FLASH_BASE) begin
            sect_a = fsp_pkg::SECT_NONE;
        end else if (addr_q >= fsp_pkg::SECT0_BASE) begin
            sect_a = fsp_pkg::SECT_0;
        end else if (addr_q >= fsp_pkg::SECT1_BASE) begin
            sect_a = fsp_pkg::SECT_1;
        end else begin
            sect_a = fsp_pkg::SECT_2;
        end
    end

    // test mode never alters flash; in-circuit mode needs the tool attached
    assign full_mode = (mode == fsp_pkg::MODE_TOOL) ||
                       (mode == fsp_pkg::MODE_INCIRCUIT && tool_s2_q);
    assign alter_ok  = !prot_q && sect_a != fsp_pkg::SECT_NONE &&
                       (full_mode || (mode == fsp_pkg::MODE_APP &&
                                      sect_a != fsp_pkg::SECT_0));
    assign pending   = |ctrl_q[fsp_pkg::OP_BITS-1:0];

    // request arbitration: block erase, sector erase, program, option
    always_comb begin
        grant_be = 1'b0;
        grant_se = 1'b0;
        grant_pg = 1'b0;
        grant_ow = 1'b0;
        refuse   = 1'b0;
        if (state_q == fsp_pkg::SEQ_IDLE && pending) begin
            if (ctrl_q[fsp_pkg::B_BERASE]) begin
                grant_be = full_mode && !prot_q;
            end else if (ctrl_q[fsp_pkg::B_SERASE]) begin
                grant_se = alter_ok;
            end else if (ctrl_q[fsp_pkg::B_PROG]) begin
                grant_pg = alter_ok;
            end else begin
                grant_ow = full_mode;
            end
            refuse = !(grant_be | grant_se | grant_pg | grant_ow);
        end
    end

    // finish marks the last busy cycle of any operation
    assign finish = state_q == fsp_pkg::SEQ_PROG ||
                    state_q == fsp_pkg::SEQ_OPTFIN ||
                    (state_q == fsp_pkg::SEQ_ERASE && cnt_q == end_q &&
                     !opt_clr_q);

    // sequencer; erase writes the erased value one byte per cycle
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= fsp_pkg::SEQ_IDLE;
            cnt_q     <= fsp_pkg::IDX_ZERO;
            end_q     <= fsp_pkg::IDX_ZERO;
            opt_clr_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            unique case (state_q)
                fsp_pkg::SEQ_IDLE: begin
                    busy_q <= grant_be | grant_se | grant_pg | grant_ow;
                    if (grant_be) begin
                        cnt_q   <= fsp_pkg::IDX_ZERO;
                        end_q   <= fsp_pkg::IDX_LAST;
                        state_q <= fsp_pkg::SEQ_ERASE;
                    end else if (grant_se) begin
                        state_q <= fsp_pkg::SEQ_ERASE;
                        unique case (sect_a)
                            fsp_pkg::SECT_0: begin
                                cnt_q <= fsp_pkg::S0_LO;
                                end_q <= fsp_pkg::IDX_LAST;
                            end
                            fsp_pkg::SECT_1: begin
                                cnt_q <= fsp_pkg::S1_LO;
                                end_q <= fsp_pkg::AW'(fsp_pkg::S0_LO - 1'b1);
                            end
                            default: begin
                                cnt_q <= fsp_pkg::IDX_ZERO;
                                end_q <= fsp_pkg::AW'(fsp_pkg::S1_LO - 1'b1);
                            end
                        endcase
                    end else if (grant_pg) begin
                        state_q <= fsp_pkg::SEQ_PROG;
                    end else if (grant_ow) begin
                        // clearing protection wipes the whole array first
                        if (prot_q && !ctrl_q[fsp_pkg::B_OPTVAL]) begin
                            opt_clr_q <= 1'b1;
                            cnt_q     <= fsp_pkg::IDX_ZERO;
                            end_q     <= fsp_pkg::IDX_LAST;
                            state_q   <= fsp_pkg::SEQ_ERASE;
                        end else begin
                            state_q <= fsp_pkg::SEQ_OPTFIN;
                        end
                    end
                end
                fsp_pkg::SEQ_PROG: begin
                    state_q <= fsp_pkg::SEQ_IDLE;
                    busy_q  <= 1'b0;
                end
                fsp_pkg::SEQ_ERASE: begin
                    if (cnt_q == end_q) begin
                        opt_clr_q <= 1'b0;
                        busy_q    <= opt_clr_q;
                        state_q   <= opt_clr_q ? fsp_pkg::SEQ_OPTFIN
                                               : fsp_pkg::SEQ_IDLE;
                    end else begin
                        cnt_q <= fsp_pkg::AW'(cnt_q + 1'b1);
                    end
                end
                fsp_pkg::SEQ_OPTFIN: begin
                    state_q <= fsp_pkg::SEQ_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // array port driven straight from the sequencer state
    assign arr.wr_en = state_q == fsp_pkg::SEQ_PROG ||
                       state_q == fsp_pkg::SEQ_ERASE;
    assign arr.waddr = state_q == fsp_pkg::SEQ_PROG ? idx_a : cnt_q;
    assign arr.wdata = state_q == fsp_pkg::SEQ_PROG ? wdat_q
                                                    : fsp_pkg::ERASED;
    assign arr.raddr = idx_a;

    // protection bit; only changed after any needed full erase
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            prot_q <= fsp_pkg::PROT_RESET;
        end else if (state_q == fsp_pkg::SEQ_OPTFIN) begin
            prot_q <= ctrl_q[fsp_pkg::B_OPTVAL];
        end
    end

    // apb: one wait state, ready and data both come from flops
    assign acc    = psel_in && penable_in && pready_q;
    assign wr_acc = acc && pwrite_in;
    assign mapped = paddr_in == fsp_pkg::REG_CTRL ||
                    paddr_in == fsp_pkg::REG_ADDR ||
                    paddr_in == fsp_pkg::REG_DATA ||
                    paddr_in == fsp_pkg::REG_STAT;
    assign stat   = {1'b0, fsp_pkg::NUM_SECT, tool_s2_q, busy_q, prot_q,
                     mode_s2_q};

    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel_in && penable_in && !pready_q;
            pslverr_q <= psel_in && penable_in && !pready_q && !mapped;
            if (psel_in && penable_in && !pready_q && !pwrite_in) begin
                unique case (paddr_in)
                    fsp_pkg::REG_CTRL: prdata_q <= {24'h0, ctrl_q};
                    fsp_pkg::REG_ADDR: prdata_q <= {16'h0, addr_q};
                    // contents stay hidden while protected
                    fsp_pkg::REG_DATA: prdata_q <= (prot_q ||
                        sect_a == fsp_pkg::SECT_NONE) ? 32'h0000_0000
                        : {24'h0, arr.rdata};
                    fsp_pkg::REG_STAT: prdata_q <= {24'h0, stat};
                    default:           prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // address and data latch; frozen while an operation runs
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= 16'h0000;
            wdat_q <= 8'h00;
        end else if (wr_acc && state_q == fsp_pkg::SEQ_IDLE && !pending) begin
            if (paddr_in == fsp_pkg::REG_ADDR) begin
                addr_q <= pwdata_in[15:0];
            end
            if (paddr_in == fsp_pkg::REG_DATA) begin
                wdat_q <= pwdata_in[7:0];
            end
        end
    end

    // control/status: op bits self-clear; refused flag set wins
    always_ff @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= fsp_pkg::CTRL_RESET;
        end else begin
            if (wr_acc && paddr_in == fsp_pkg::REG_CTRL) begin
                if (state_q == fsp_pkg::SEQ_IDLE && !pending) begin
                    ctrl_q[fsp_pkg::LOAD_BITS-1:0] <=
                        pwdata_in[fsp_pkg::LOAD_BITS-1:0];
                end
                if (!pwdata_in[fsp_pkg::B_REFUSED]) begin
                    ctrl_q[fsp_pkg::B_REFUSED] <= 1'b0;
                end
            end
            if (refuse || finish) begin
                ctrl_q[fsp_pkg::OP_BITS-1:0] <= '0;
            end
            if (refuse) begin
                ctrl_q[fsp_pkg::B_REFUSED] <= 1'b1;
            end
        end
    end

    assign prdata_out                 = prdata_q;
    assign pready_out                 = pready_q;
    assign pslverr_out                = pslverr_q;
    assign link_pin_o_out             = pin_o_q;
    assign link_pin_oe_out            = pin_oe_q;
    assign readout_protect_option_out = prot_q;
    assign busy_out                   = busy_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b);

    // any sector erase request in application mode, granted or not
    sequence s_se_app;
        state_q == fsp_pkg::SEQ_IDLE && ctrl_q[fsp_pkg::B_SERASE] &&
            !ctrl_q[fsp_pkg::B_BERASE] && mode == fsp_pkg::MODE_APP;
    endsequence
    sequence s_opt_remove;
        grant_ow && prot_q && !ctrl_q[fsp_pkg::B_OPTVAL];
    endsequence

    property p_app_keeps_s0;
        s_se_app |=> (!(arr.wr_en && arr.waddr >= fsp_pkg::S0_LO)) [*8];
    endproperty
    a_app_keeps_s0: assert property (p_app_keeps_s0)
        else $error("application mode erase touched sector 0");

    property p_prot_no_prog;
        prot_q && state_q == fsp_pkg::SEQ_IDLE && ctrl_q[fsp_pkg::B_PROG]
            |=> state_q == fsp_pkg::SEQ_IDLE && !arr.wr_en;
    endproperty
    a_prot_no_prog: assert property (p_prot_no_prog)
        else $error("program accepted while read-out protected");

    property p_remove_erases;
        s_opt_remove |=> state_q == fsp_pkg::SEQ_ERASE && prot_q &&
            cnt_q == fsp_pkg::IDX_ZERO ##1 (prot_q && arr.wr_en) [*8];
    endproperty
    a_remove_erases: assert property (p_remove_erases)
        else $error("protection removed without full erase");

    property p_refuse_flag;
        refuse |=> ctrl_q[fsp_pkg::B_REFUSED] && !pending &&
            state_q == fsp_pkg::SEQ_IDLE ##1 !arr.wr_en;
    endproperty
    a_refuse_flag: assert property (p_refuse_flag)
        else $error("refused request not flagged or acted on");

    property p_ctrl_reset;
        $rose(rst_b) |-> ctrl_q == fsp_pkg::CTRL_RESET;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("control register not zero after reset");

    property p_tool_pins;
        tool_s2_q |=> link_pin_oe_out == 2'h0 && link_pin_o_out == 2'h0;
    endproperty
    a_tool_pins: assert property (p_tool_pins)
        else $error("application drives link pins with tool attached");

    property p_prog_one_byte;
        grant_pg |=> arr.wr_en && arr.wdata == $past(wdat_q) &&
            arr.waddr == $past(idx_a) ##1 !arr.wr_en && !busy_out;
    endproperty
    a_prog_one_byte: assert property (p_prog_one_byte)
        else $error("program did not write exactly one byte");

    property p_s0_decode;
        state_q == fsp_pkg::SEQ_IDLE
            |-> (sect_a == fsp_pkg::SECT_0) == (addr_q[15:12] == 4'hF);
    endproperty
    a_s0_decode: assert property (p_s0_decode)
        else $error("sector 0 decoded outside F000h-FFFFh");

    property p_erase_in_range;
        state_q == fsp_pkg::SEQ_ERASE |-> cnt_q <= end_q;
    endproperty
    a_erase_in_range: assert property (p_erase_in_range)
        else $error("erase walked past its sector end");
endmodule

/* File: common/fsp_pkg.sv */
// constants, field layout and types of the flash sector program access block
package fsp_pkg;
    // apb byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    // control/status fields
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int B_PROG    = 0;
    localparam int B_SERASE  = 1;
    localparam int B_BERASE  = 2;
    localparam int B_OPTWR   = 3;
    localparam int B_OPTVAL  = 4;
    localparam int B_REFUSED = 5;
    localparam int OP_BITS   = 4;
    localparam int LOAD_BITS = 5;
    // status register fields
    localparam int S_MODE  = 0;
    localparam int S_PROT  = 2;
    localparam int S_BUSY  = 3;
    localparam int S_TOOL  = 4;
    localparam int S_NSECT = 5;
    // array geometry
    localparam int          FLASH_BYTES = 16384;
    localparam int          SECT_BYTES  = 4096;
    localparam int          AW          = $clog2(FLASH_BYTES);
    localparam logic [16:0] ADDR_TOP    = 17'h10000;
    localparam logic [16:0] FLASH_BASE  = 17'(ADDR_TOP - FLASH_BYTES);
    localparam logic [15:0] SECT0_BASE  = 16'hF000;
    localparam logic [15:0] SECT1_BASE  = 16'hE000;
    localparam logic [AW-1:0] IDX_LAST = AW'(FLASH_BYTES - 1);
    localparam logic [AW-1:0] S0_LO    = AW'(FLASH_BYTES - SECT_BYTES);
    localparam logic [AW-1:0] S1_LO    = AW'(FLASH_BYTES - 2 * SECT_BYTES);
    localparam logic [AW-1:0] IDX_ZERO = AW'(0);
    localparam logic [1:0]  NUM_SECT = (FLASH_BYTES <= SECT_BYTES) ? 2'h1 :
                                       (FLASH_BYTES <= 2 * SECT_BYTES) ? 2'h2
                                                                       : 2'h3;
    localparam logic [7:0]  ERASED     = 8'hFF;
    localparam logic        PROT_RESET = 1'b0;
    // sector numbers
    typedef enum logic [1:0] {
        SECT_0    = 2'h0,
        SECT_1    = 2'h1,
        SECT_2    = 2'h2,
        SECT_NONE = 2'h3
    } fsp_sect_e;
    // programming mode straps
    typedef enum logic [1:0] {
        MODE_TOOL      = 2'h0,
        MODE_INCIRCUIT = 2'h1,
        MODE_TEST      = 2'h2,
        MODE_APP       = 2'h3
    } fsp_mode_e;
    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'h0,
        SEQ_PROG   = 2'h1,
        SEQ_ERASE  = 2'h3,
        SEQ_OPTFIN = 2'h2
    } fsp_state_e;
endpackage

/* File: common/fsp_arr_if.sv */
// byte port between the sequencer and the flash array
interface fsp_arr_if;
    logic                   wr_en;
    logic [fsp_pkg::AW-1:0] waddr;
    logic [7:0]             wdata;
    logic [fsp_pkg::AW-1:0] raddr;
    logic [7:0]             rdata;
    modport ctrl (output wr_en, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input wr_en, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

/* File: design/fsp_flash_array.sv */
// byte-wide flash array storage, one byte written per cycle
module fsp_flash_array (
    // clock
    input  wire logic clk_in,
    // byte port
    fsp_arr_if.mem    arr
);
    // contents survive reset on purpose: this models non-volatile cells
    logic [7:0] mem_q [fsp_pkg::FLASH_BYTES];

    // only the addressed byte changes, so other sectors are untouched
    always_ff @(posedge clk_in) begin
        if (arr.wr_en) begin
            mem_q[arr.waddr] <= arr.wdata;
        end
    end

    // asynchronous read keeps the apb data path one cycle deep
    assign arr.rdata = mem_q[arr.raddr];
endmodule

/* File: sim/fsp_tool_model.sv */
// behavioural programming tool: reset pin, mode straps and presence
module fsp_tool_model (
    // control from the bench
    input  wire logic       plugged_in,
    input  wire logic       hold_rst_in,
    input  wire logic [1:0] mode_req_in,
    // pins toward the device
    output logic            rst_b_out,
    output logic [1:0]      mode_sel_out,
    output logic            tool_attached_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // the tool owns reset; the application never pulls it meanwhile
    assign rst_b_out = ~hold_rst_in;
    // straps follow the requested mode while plugged; unplugged runs the app
    assign mode_sel_out = plugged_in ? mode_req_in : 2'h3;
    assign tool_attached_out = plugged_in;
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the flash sector program access block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 1'b0;
    logic        hold_rst = 1'b1;
    logic        plugged = 1'b1;
    logic [1:0]  mode_req = 2'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  app_o = 2'h2;
    logic [1:0]  app_oe = 2'h3;
    logic        rst_b;
    logic        tool_att;
    logic [1:0]  mode_sel;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [1:0]  link_oe;
    logic [1:0]  link_o;
    logic        prot;
    logic        busy_out;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    always #2.5 clk_in = ~clk_in;

    fsp_tool_model i_tool (.plugged_in(plugged), .hold_rst_in(hold_rst),
        .mode_req_in(mode_req), .rst_b_out(rst_b),
        .mode_sel_out(mode_sel), .tool_attached_out(tool_att));
    fsp_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .mode_sel_in(mode_sel), .tool_attached_in(tool_att),
        .app_pin_o_in(app_o), .app_pin_oe_in(app_oe),
        .link_pin_o_out(link_o), .link_pin_oe_out(link_oe),
        .readout_protect_option_out(prot), .busy_out(busy_out));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard: all tests need about 41300 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; the answer is taken at the edge pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // values read here are those sampled at this rising edge
        @(posedge clk_in);
        while (pready_out !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_in);
        end
        if (pready_out !== 1'b1) begin
            errors++;
            $display("[ERR] pready expected 1 seen 0");
        end
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // start an operation and wait, bounded, for busy to drop
    task automatic op(input logic [7:0] v);
        int n;
        n = 0;
        apb(1'b1, fsp_pkg::REG_CTRL, {24'h0, v});
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        while (busy_out !== 1'b0 && n < 20000) begin
            n++;
            @(negedge clk_in);
        end
        if (busy_out !== 1'b0) begin
            errors++;
            $display("[ERR] busy expected 0 seen 1");
        end
    endtask

    task automatic peek(input logic [15:0] a, input logic [7:0] e);
        apb(1'b1, fsp_pkg::REG_ADDR, {16'h0, a});
        apb(1'b0, fsp_pkg::REG_DATA, 32'h0);
        chk("flash byte", rd, {24'h0, e});
    endtask

    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, fsp_pkg::REG_ADDR, {16'h0, a});
        apb(1'b1, fsp_pkg::REG_DATA, {24'h0, d});
        op(8'h01);
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        hold_rst <= 1'b0;
        repeat (5) @(posedge clk_in);
        apb(1'b0, fsp_pkg::REG_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b0, fsp_pkg::REG_STAT, 32'h0);
        chk("status", rd, {25'h0, fsp_pkg::NUM_SECT, 5'h10});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        $display("test reset done");
        // tool mode: block erase, then one byte in each sector
        op(8'h04);
        peek(16'hD123, 8'hFF);
        poke(16'hF000, 8'h5A);
        poke(16'hE000, 8'hA5);
        poke(16'hC000, 8'h3C);
        peek(16'hF000, 8'h5A);
        apb(1'b1, fsp_pkg::REG_ADDR, 32'hEFFF);
        op(8'h02);
        peek(16'hE000, 8'hFF);
        peek(16'hF000, 8'h5A);
        peek(16'hC000, 8'h3C);
        $display("test sectors done");
        // application mode: sector 0 stays locked, sector 1 is open
        mode_req <= 2'h3;
        repeat (4) @(posedge clk_in);
        poke(16'hFFFF, 8'h11);
        apb(1'b0, fsp_pkg::REG_CTRL, 32'h0);
        chk("ctrl refused", rd, 32'h20);
        peek(16'hFFFF, 8'hFF);
        apb(1'b1, fsp_pkg::REG_CTRL, 32'h0);
        poke(16'hC000, 8'h00);
        peek(16'hC000, 8'h00);
        poke(16'hE000, 8'h66);
        peek(16'hE000, 8'h66);
        apb(1'b1, fsp_pkg::REG_ADDR, 32'hF800);
        op(8'h02);
        peek(16'hF000, 8'h5A);
        apb(1'b1, fsp_pkg::REG_ADDR, 32'hE800);
        op(8'h02);
        peek(16'hE000, 8'hFF);
        peek(16'hC000, 8'h00);
        $display("test app mode done");
        // test mode may alter nothing
        mode_req <= 2'h2;
        repeat (4) @(posedge clk_in);
        poke(16'hC000, 8'h55);
        apb(1'b0, fsp_pkg::REG_CTRL, 32'h0);
        chk("test mode refused", rd, 32'h20);
        peek(16'hC000, 8'h00);
        $display("test mode done");
        // link pins belong to the tool while plugged in
        chk("pins plugged", {30'h0, link_oe}, 32'h0);
        chk("pin drive plugged", {30'h0, link_o}, 32'h0);
        plugged <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("pins free", {30'h0, link_oe}, 32'h3);
        chk("pin drive free", {30'h0, link_o}, 32'h2);
        plugged <= 1'b1;
        mode_req <= 2'h1;
        repeat (6) @(posedge clk_in);
        $display("test pins done");
        // protection on, refused program, then removal erases all
        op(8'h18);
        chk("prot on", {31'h0, prot}, 32'h1);
        peek(16'hF000, 8'h00);
        poke(16'hE000, 8'h77);
        apb(1'b0, fsp_pkg::REG_CTRL, 32'h0);
        chk("prot refused", rd, 32'h20);
        op(8'h08);
        chk("prot off", {31'h0, prot}, 32'h0);
        peek(16'hF000, 8'hFF);
        peek(16'hE000, 8'hFF);
        $display("test protection done");
        end_of_test();
    end
endmodule
